// >>> core/cxb_exec.sv
// compare, exclusive-or, barrier and load-multiple execute unit with bus register window
`timescale 1ns/1ps

module cxb_exec
    import cxb_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic              issue_valid,
    input  wire logic [31:0]       issue_instr,
    input  wire logic              issue_wide,
    input  wire logic              in_cond_block,
    output logic                   issue_ready,
    output logic                   exec_done,
    output logic                   flush_pipe,
    input  wire logic              mem_idle,
    input  wire logic              maint_idle,
    output logic                   mem_req,
    output logic [31:0]            mem_addr,
    input  wire logic              mem_rvalid,
    input  wire logic [31:0]       mem_rdata
);

    typedef struct packed {
        cxb_state_e                st;
        logic [CXB_NREG-1:0][31:0] rf;
        logic [3:0]                flags;
        logic                      dmb_pend;
        logic [7:0]                list;
        logic [3:0]                base;
        logic                      wb;
        logic                      mem_req;
        logic [31:0]               mem_addr;
        logic                      ready;
        logic                      done;
        logic                      flush;
        logic [3:0]                last_opt;
        logic                      ap_wr;
        logic [7:0]                ap_addr;
        logic [31:0]               hrdata;
        logic                      hrdy;
        logic                      hresp;
    } cxb_state_s;

    cxb_state_s r;
    cxb_state_s n;

    logic [15:0] hw1;
    logic [15:0] hw2;
    logic        take;
    logic        is_cmp_narrow;
    logic        is_cmp_high;
    logic        is_cmp;
    logic        is_xor;
    logic        is_ldm;
    logic        is_bar;
    logic        is_dmb;
    logic        is_dsb;
    logic        is_isb;
    logic [3:0]  idx_a;
    logic [3:0]  idx_b;
    logic [31:0] val_a;
    logic [31:0] val_b;
    logic [32:0] cmp_sum;
    logic        cmp_ovf;
    logic [31:0] xor_res;
    logic [2:0]  ldm_idx;
    logic        ap_take;
    logic [31:0] rd_word;

    function automatic logic [2:0] lowest_bit(input logic [7:0] v);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    assign hw1 = issue_instr[31:16];
    assign hw2 = issue_instr[15:0];
    assign take = issue_valid && r.ready;

    assign is_cmp_narrow = !issue_wide && (hw2[15:6] == CXB_OP_CMP_NARROW);
    assign is_cmp_high   = !issue_wide && (hw2[15:8] == CXB_OP_CMP_HIGH);
    assign is_cmp        = is_cmp_narrow || is_cmp_high;
    assign is_xor        = !issue_wide && (hw2[15:6] == CXB_OP_XOR);
    assign is_ldm        = !issue_wide && (hw2[15:11] == CXB_OP_LDM);
    assign is_bar        = issue_wide && (hw1[15:4] == CXB_OP_BAR_HW1)
                           && (hw2[15:14] == CXB_OP_BAR_HW2) && !hw2[12];
    assign is_dmb        = is_bar && (hw2[7:4] == CXB_BAR_DMB);
    assign is_dsb        = is_bar && (hw2[7:4] == CXB_BAR_DSB);
    assign is_isb        = is_bar && (hw2[7:4] == CXB_BAR_ISB);

    // high form reaches all sixteen registers, stack pointer included
    assign idx_a = is_cmp_high ? {hw2[7], hw2[2:0]} : {1'b0, hw2[2:0]};
    assign idx_b = is_cmp_high ? hw2[6:3] : {1'b0, hw2[5:3]};
    assign val_a = r.rf[idx_a];
    assign val_b = r.rf[idx_b];

    // shift is always zero here, so the shifter carry is the old carry
    assign cmp_sum = {1'b0, val_a} + {1'b0, ~val_b} + 33'h0_0000_0001;
    assign cmp_ovf = (val_a[31] ^ val_b[31]) & (val_a[31] ^ cmp_sum[31]);
    assign xor_res = val_a ^ val_b;

    assign ldm_idx = lowest_bit(r.list);
    assign ap_take = hsel && htrans[1] && hready;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (haddr[7:6] == CXB_OFF_RF[7:6]) begin
            rd_word = r.rf[haddr[5:2]];
        end else if (haddr[7:0] == CXB_OFF_FLAGS) begin
            rd_word[CXB_FLAGS_POS +: 4] = r.flags;
        end else if (haddr[7:0] == CXB_OFF_STATUS) begin
            rd_word[3:0] = r.st;
            rd_word[CXB_ST_DMB_POS] = r.dmb_pend;
            rd_word[CXB_ST_OPT_POS +: 4] = r.last_opt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = r;
        n.done = 1'b0;
        n.flush = 1'b0;
        // a fresh barrier wins over the drain seen in the same cycle
        if (mem_idle) begin
            n.dmb_pend = 1'b0;
        end
        unique case (r.st)
            CXB_IDLE: begin
                if (take) begin
                    if (is_cmp) begin
                        n.flags[CXB_FLG_N] = cmp_sum[31];
                        n.flags[CXB_FLG_Z] = (cmp_sum[31:0] == 32'h0000_0000);
                        n.flags[CXB_FLG_C] = cmp_sum[32];
                        n.flags[CXB_FLG_V] = cmp_ovf;
                        n.done = 1'b1;
                    end else if (is_xor) begin
                        n.rf[idx_a] = xor_res;
                        if (!in_cond_block) begin
                            n.flags[CXB_FLG_N] = xor_res[31];
                            n.flags[CXB_FLG_Z] = (xor_res == 32'h0000_0000);
                        end
                        n.done = 1'b1;
                    end else if (is_ldm) begin
                        n.list = hw2[7:0];
                        n.base = {1'b0, hw2[10:8]};
                        n.wb = !hw2[hw2[10:8]];
                        n.mem_addr = r.rf[{1'b0, hw2[10:8]}];
                        n.st = CXB_LDM;
                    end else if (is_dmb) begin
                        // every option value runs the full ordering
                        n.last_opt = hw2[3:0];
                        n.dmb_pend = 1'b1;
                        n.done = 1'b1;
                    end else if (is_dsb) begin
                        n.last_opt = hw2[3:0];
                        n.st = CXB_DSB;
                    end else if (is_isb) begin
                        n.last_opt = hw2[3:0];
                        n.st = CXB_ISB;
                    end else begin
                        n.done = 1'b1;
                    end
                end
            end
            CXB_LDM: begin
                if (r.mem_req) begin
                    if (mem_rvalid) begin
                        n.rf[{1'b0, ldm_idx}] = mem_rdata;
                        n.list[ldm_idx] = 1'b0;
                        n.mem_addr = r.mem_addr + CXB_WORD_STEP;
                        n.mem_req = 1'b0;
                    end
                end else if (r.list == 8'h00) begin
                    // running address now equals base plus four per word
                    if (r.wb) begin
                        n.rf[r.base] = r.mem_addr;
                    end
                    n.st = CXB_IDLE;
                    n.done = 1'b1;
                end else if (!r.dmb_pend) begin
                    n.mem_req = 1'b1;
                end
            end
            CXB_DSB: begin
                if (mem_idle && maint_idle) begin
                    n.st = CXB_IDLE;
                    n.done = 1'b1;
                end
            end
            CXB_ISB: begin
                // wait for context writes to land before the refetch
                if (mem_idle) begin
                    n.flush = 1'b1;
                    n.st = CXB_IDLE;
                    n.done = 1'b1;
                end
            end
        endcase
        n.ready = (n.st == CXB_IDLE);
        n.hrdy = 1'b1;
        n.hresp = 1'b0;
        n.ap_wr = ap_take && hwrite;
        n.ap_addr = haddr[7:0];
        if (ap_take && !hwrite) begin
            n.hrdata = rd_word;
        end
        // bus writes land last, so software wins over the unit
        if (r.ap_wr) begin
            if (r.ap_addr[7:6] == CXB_OFF_RF[7:6]) begin
                n.rf[r.ap_addr[5:2]] = hwdata;
            end else if (r.ap_addr == CXB_OFF_FLAGS) begin
                n.flags = hwdata[CXB_FLAGS_POS +: 4];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.st <= CXB_IDLE;
            r.rf <= {CXB_NREG{CXB_RF_RST}};
            r.flags <= CXB_FLAGS_RST;
            r.dmb_pend <= 1'b0;
            r.list <= 8'h00;
            r.base <= 4'h0;
            r.wb <= 1'b0;
            r.mem_req <= 1'b0;
            r.mem_addr <= 32'h0000_0000;
            r.ready <= 1'b1;
            r.done <= 1'b0;
            r.flush <= 1'b0;
            r.last_opt <= CXB_OPT_RST;
            r.ap_wr <= 1'b0;
            r.ap_addr <= 8'h00;
            r.hrdata <= 32'h0000_0000;
            r.hrdy <= 1'b1;
            r.hresp <= 1'b0;
        end else begin
            r <= n;
        end
    end

    assign hreadyout   = r.hrdy;
    assign hrdata      = r.hrdata;
    assign hresp       = r.hresp;
    assign issue_ready = r.ready;
    assign exec_done   = r.done;
    assign flush_pipe  = r.flush;
    assign mem_req     = r.mem_req;
    assign mem_addr    = r.mem_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cmp_flag_set: assert property (
        take && is_cmp && !r.ap_wr |=> r.flags[CXB_FLG_N] == $past(cmp_sum[31])
            && r.flags[CXB_FLG_C] == $past(cmp_sum[32]) && r.flags[CXB_FLG_V] == $past(cmp_ovf))
        else $error("compare flags wrong");

    a_cmp_sp_zero: assert property (
        take && is_cmp_high && hw2[6:3] == CXB_SP_IDX && !r.ap_wr
            |=> r.flags[CXB_FLG_Z] == ($past(val_a) == $past(r.rf[CXB_SP_IDX])))
        else $error("compare with stack pointer wrong");

    a_dmb_hold_load: assert property (
        r.st == CXB_LDM && r.dmb_pend && !r.mem_req |=> !r.mem_req)
        else $error("load issued past pending barrier");

    a_dmb_no_stall: assert property (
        take && is_dmb |=> r.ready && r.done)
        else $error("memory barrier stalled issue");

    a_dsb_hold_off: assert property (
        r.st == CXB_DSB && !(mem_idle && maint_idle) |=> !r.ready && r.st == CXB_DSB)
        else $error("sync barrier released early");

    a_dsb_complete: assert property (
        r.st == CXB_DSB && mem_idle && maint_idle |=> r.ready ##0 r.done)
        else $error("sync barrier did not complete");

    a_isb_flush_seq: assert property (
        take && is_isb |=> !r.ready ##0 (r.st == CXB_ISB) [*1] ##1 (r.flush || r.st == CXB_ISB))
        else $error("instruction barrier flush missing");

    a_xor_write: assert property (
        take && is_xor && !r.ap_wr |=> r.rf[$past(idx_a)] == $past(xor_res))
        else $error("xor result wrong");

    a_xor_keep_v: assert property (
        take && is_xor && !r.ap_wr |=> r.flags[CXB_FLG_V] == $past(r.flags[CXB_FLG_V]))
        else $error("xor touched overflow");

    a_ldm_step: assert property (
        r.st == CXB_LDM && r.mem_req && mem_rvalid |=> r.mem_addr == $past(r.mem_addr) + CXB_WORD_STEP)
        else $error("load address did not advance by a word");

    a_bar_opt_keep: assert property (
        take && (is_dmb || is_dsb || is_isb) |=> r.last_opt == $past(hw2[3:0]))
        else $error("barrier option not recorded");

    a_xor_cond_keep: assert property (
        take && is_xor && in_cond_block && !r.ap_wr |=> r.flags == $past(r.flags))
        else $error("xor in conditional block changed flags");

    a_xor_flag_nz: assert property (
        take && is_xor && !in_cond_block && !r.ap_wr |=> r.flags[CXB_FLG_N] == $past(xor_res[31])
            && r.flags[CXB_FLG_Z] == ($past(xor_res) == 32'h0000_0000))
        else $error("xor flags wrong");

    a_ldm_wback: assert property (
        r.st == CXB_LDM && !r.mem_req && r.list == 8'h00 && r.wb && !r.ap_wr
            |=> r.rf[$past(r.base)] == $past(r.mem_addr))
        else $error("load-multiple write-back wrong");

    a_isb_wait_idle: assert property (
        r.st == CXB_ISB && !mem_idle |=> !r.flush && r.st == CXB_ISB)
        else $error("instruction barrier flushed before context settled");

    a_ldm_list_load: assert property (
        take && is_ldm |=> r.list == $past(hw2[7:0]) && r.base == {1'b0, $past(hw2[10:8])})
        else $error("load-multiple list or base wrong");

    c_ldm_run:  cover property (take && is_ldm ##[1:40] r.done);
    c_dsb_wait: cover property (r.st == CXB_DSB ##1 r.st == CXB_DSB ##1 r.st == CXB_IDLE);
    c_isb_done: cover property (r.flush);
    c_dmb_hold: cover property (r.dmb_pend && r.st == CXB_LDM);
    c_xor_cond: cover property (take && is_xor && in_cond_block);

endmodule

// >>> pkg/cxb_pkg.sv
// constants, encodings and state codes of the compare/xor/barrier/load-multiple unit
package cxb_pkg;

    localparam int unsigned CXB_DW        = 32;
    localparam int unsigned CXB_NREG      = 16;

    // register map, byte addresses on the bus
    localparam logic [7:0]  CXB_OFF_RF     = 8'h00;
    localparam logic [7:0]  CXB_OFF_FLAGS  = 8'h40;
    localparam logic [7:0]  CXB_OFF_STATUS = 8'h44;

    // flag field positions inside the flags nibble and the flags word, and field positions inside the status word
    localparam int unsigned CXB_FLG_N      = 3;
    localparam int unsigned CXB_FLG_Z      = 2;
    localparam int unsigned CXB_FLG_C      = 1;
    localparam int unsigned CXB_FLG_V      = 0;
    localparam int unsigned CXB_FLAGS_POS  = 28;
    localparam int unsigned CXB_ST_OPT_POS = 8;
    localparam int unsigned CXB_ST_DMB_POS = 4;

    // reset values
    localparam logic [3:0]  CXB_FLAGS_RST  = 4'h0;
    localparam logic [31:0] CXB_RF_RST     = 32'h0000_0000;
    localparam logic [3:0]  CXB_OPT_RST    = 4'hF;

    // instruction encodings
    localparam logic [9:0]  CXB_OP_CMP_NARROW = 10'h10A;
    localparam logic [7:0]  CXB_OP_CMP_HIGH   = 8'h45;
    localparam logic [9:0]  CXB_OP_XOR        = 10'h101;
    localparam logic [4:0]  CXB_OP_LDM        = 5'h19;
    localparam logic [11:0] CXB_OP_BAR_HW1    = 12'hF3B;
    localparam logic [1:0]  CXB_OP_BAR_HW2    = 2'h2;
    localparam logic [3:0]  CXB_BAR_DMB       = 4'h5;
    localparam logic [3:0]  CXB_BAR_DSB       = 4'h4;
    localparam logic [3:0]  CXB_BAR_ISB       = 4'h6;
    localparam logic [3:0]  CXB_OPT_FULL      = 4'hF;
    localparam logic [3:0]  CXB_SP_IDX        = 4'hD;
    localparam logic [31:0] CXB_WORD_STEP     = 32'h0000_0004;

    typedef enum logic [3:0] {
        CXB_IDLE = 4'h1,
        CXB_LDM  = 4'h2,
        CXB_DSB  = 4'h4,
        CXB_ISB  = 4'h8
    } cxb_state_e;

endpackage

// >>> testbench/cxb_exec_bench.sv
// self-checking bench for the compare, xor, barrier and load-multiple unit
`timescale 1ns/1ps
module cxb_exec_bench;
    import cxb_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, fl_seen;
    logic        issue_valid, issue_wide, in_cond_block, issue_ready, exec_done, flush_pipe;
    logic        mem_idle, maint_idle, mem_req, mem_rvalid, busy, maint_busy;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  lat;
    logic [31:0] haddr, hwdata, hrdata, issue_instr, mem_addr, mem_rdata, q;
    int          err_count, compares, n;
    assign hready = hreadyout;
    cxb_exec DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .issue_valid(issue_valid), .issue_instr(issue_instr),
        .issue_wide(issue_wide), .in_cond_block(in_cond_block), .issue_ready(issue_ready),
        .exec_done(exec_done), .flush_pipe(flush_pipe), .mem_idle(mem_idle), .maint_idle(maint_idle),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    cxb_mem_model MEM (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_addr(mem_addr),
        .lat(lat), .busy(busy), .maint_busy(maint_busy), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_idle(mem_idle), .maint_idle(maint_idle));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic c1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    // bounded wait for a flag sampled at a rising edge
    task automatic wait_hi(input string nm, ref logic f);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (f !== 1'b1 && n < 60);
        if (f !== 1'b1) begin
            c1(nm, 1'b1, f);
            final_report();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_hi("hready", hready);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi("hready", hready);
        q = hrdata;
        c1("hresp", 1'b0, hresp);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic issue(input logic [31:0] ins, input logic w, input logic c);
        @(posedge hclk);
        issue_valid   <= 1'b1;
        issue_instr   <= ins;
        issue_wide    <= w;
        in_cond_block <= c;
        wait_hi("issue_ready", issue_ready);
        issue_valid <= 1'b0;
    endtask
    task automatic run(input logic [31:0] ins, input logic w, input logic c);
        issue(ins, w, c);
        wait_hi("exec_done", exec_done);
        fl_seen = flush_pipe;
    endtask
    function automatic logic [3:0] cmpf(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, ~b} + 33'h1;
        return {s[31], s[31:0] == 32'h0, s[32], (a[31] != b[31]) && (s[31] != a[31])};
    endfunction
    function automatic logic [31:0] bar(input logic [3:0] k, input logic [3:0] o);
        return {CXB_OP_BAR_HW1, 4'hF, CXB_OP_BAR_HW2, 2'h0, 4'hF, k, o};
    endfunction
    function automatic logic [31:0] mf(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rc("r13", 8'h34, CXB_RF_RST);
        rc("flags", CXB_OFF_FLAGS, 32'h0);
        rc("status", CXB_OFF_STATUS, 32'h0000_0F01);
        rc("unmapped", 8'h80, 32'h0);
    endtask
    task automatic t_compare();
        logic [31:0] av [4] = '{32'h5, 32'h7, 32'h8000_0000, 32'h3};
        logic [31:0] bv [4] = '{32'h7, 32'h5, 32'h1, 32'h3};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h04, av[i]);
            bus(1'b1, 8'h08, bv[i]);
            bus(1'b1, 8'h34, bv[i]);
            run({16'h0, CXB_OP_CMP_NARROW, 3'h2, 3'h1}, 1'b0, 1'b0);
            chk("cmp cycles", 32'h1, n);
            rc("flags", CXB_OFF_FLAGS, {cmpf(av[i], bv[i]), 28'h0});
            rc("r1", 8'h04, av[i]);
            run({16'h0, CXB_OP_CMP_HIGH, 1'b0, 4'hD, 3'h1}, 1'b0, 1'b0);
            rc("flags", CXB_OFF_FLAGS, {cmpf(av[i], bv[i]), 28'h0});
            run({16'h0, CXB_OP_CMP_HIGH, 1'b1, 4'h1, 3'h5}, 1'b0, 1'b0);
            rc("flags", CXB_OFF_FLAGS, {cmpf(bv[i], av[i]), 28'h0});
        end
    endtask
    task automatic t_xor();
        bus(1'b1, CXB_OFF_FLAGS, 32'h3000_0000);
        bus(1'b1, 8'h0C, 32'h8000_00FF);
        bus(1'b1, 8'h10, 32'h0000_00FF);
        run({16'h0, CXB_OP_XOR, 3'h4, 3'h3}, 1'b0, 1'b0);
        rc("r3", 8'h0C, 32'h8000_0000);
        rc("r4", 8'h10, 32'h0000_00FF);
        rc("flags", CXB_OFF_FLAGS, 32'hB000_0000);
        run({16'h0, CXB_OP_XOR, 3'h3, 3'h3}, 1'b0, 1'b0);
        rc("r3", 8'h0C, 32'h0);
        rc("flags", CXB_OFF_FLAGS, 32'h7000_0000);
        bus(1'b1, CXB_OFF_FLAGS, 32'h0);
        bus(1'b1, 8'h0C, 32'h8000_0001);
        run({16'h0, CXB_OP_XOR, 3'h4, 3'h3}, 1'b0, 1'b1);
        rc("r3", 8'h0C, 32'h8000_00FE);
        rc("flags", CXB_OFF_FLAGS, 32'h0);
    endtask
    task automatic t_mem_barrier();
        for (int o = 0; o < 16; o++) begin
            run(bar(CXB_BAR_DMB, o[3:0]), 1'b1, 1'b0);
            chk("dmb cycles", 32'h1, n);
            c1("flush", 1'b0, fl_seen);
            rc("status", CXB_OFF_STATUS, {20'h0, o[3:0], 8'h01});
        end
        busy <= 1'b1;
        run(bar(CXB_BAR_DMB, 4'hF), 1'b1, 1'b0);
        chk("dmb busy cycles", 32'h1, n);
        rc("status", CXB_OFF_STATUS, 32'h0000_0F11);
        bus(1'b1, 8'h04, 32'h0000_0100);
        issue({16'h0, CXB_OP_LDM, 3'h1, 8'h01}, 1'b0, 1'b0);
        repeat (6) begin
            @(posedge hclk);
            c1("mem_req", 1'b0, mem_req);
        end
        busy <= 1'b0;
        wait_hi("exec_done", exec_done);
        rc("r0", 8'h00, mf(32'h100));
        rc("r1", 8'h04, 32'h0000_0104);
    endtask
    task automatic t_sync_barrier();
        for (int k = 0; k < 2; k++) begin
            if (k == 0) busy <= 1'b1;
            else maint_busy <= 1'b1;
            issue(bar(CXB_BAR_DSB, k ? 4'hF : 4'h3), 1'b1, 1'b0);
            repeat (5) begin
                @(posedge hclk);
                c1("dsb done", 1'b0, exec_done);
                c1("dsb ready", 1'b0, issue_ready);
            end
            rc("status", CXB_OFF_STATUS, k ? 32'h0000_0F04 : 32'h0000_0304);
            busy       <= 1'b0;
            maint_busy <= 1'b0;
            wait_hi("exec_done", exec_done);
            c1("dsb flush", 1'b0, flush_pipe);
        end
        for (int k = 0; k < 2; k++) begin
            busy <= 1'b1;
            issue(bar(CXB_BAR_ISB, k ? 4'h0 : 4'hF), 1'b1, 1'b0);
            repeat (5) begin
                @(posedge hclk);
                c1("isb early", 1'b0, flush_pipe);
            end
            rc("status", CXB_OFF_STATUS, k ? 32'h0000_0008 : 32'h0000_0F08);
            busy <= 1'b0;
            wait_hi("flush_pipe", flush_pipe);
            c1("isb done", 1'b1, exec_done);
            run(32'h0, 1'b0, 1'b0);
            c1("no flush", 1'b0, fl_seen);
        end
    endtask
    task automatic t_load_multiple();
        lat <= 4'h3;
        bus(1'b1, 8'h04, 32'h0000_0100);
        run({16'h0, CXB_OP_LDM, 3'h1, 8'h05}, 1'b0, 1'b0);
        rc("r0", 8'h00, mf(32'h100));
        rc("r2", 8'h08, mf(32'h104));
        rc("r1", 8'h04, 32'h0000_0108);
        bus(1'b1, 8'h0C, 32'h0000_0200);
        run({16'h0, CXB_OP_LDM, 3'h3, 8'h18}, 1'b0, 1'b0);
        rc("r3", 8'h0C, mf(32'h200));
        rc("r4", 8'h10, mf(32'h204));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, issue_valid, issue_wide, in_cond_block, busy, maint_busy} = 8'h0;
        {htrans, haddr, hwdata, issue_instr, lat, fl_seen} = '0;
        hsize     = 3'h2;
        err_count = 0;
        compares  = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_compare();
        t_xor();
        t_mem_barrier();
        t_sync_barrier();
        t_load_multiple();
        final_report();
    end
endmodule

// >>> testbench/cxb_mem_model.sv
// data memory partner: answers loads after a set latency, reports idle levels
`timescale 1ns/1ps
module cxb_mem_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [3:0]  lat,
    input  wire logic        busy,
    input  wire logic        maint_busy,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata,
    output logic             mem_idle,
    output logic             maint_idle
);
    logic [3:0] cnt;
    assign mem_idle   = !busy;
    assign maint_idle = !maint_busy;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt        <= 4'h0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 32'h0000_0000;
        end else if (mem_req && !mem_rvalid && cnt >= lat) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= {mem_addr[15:0], ~mem_addr[15:0]};
            cnt        <= 4'h0;
        end else begin
            mem_rvalid <= 1'b0;
            // stale data toggles so a late sample cannot pass by luck
            mem_rdata  <= ~mem_rdata;
            cnt        <= mem_req ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule
